// *** design/pbe_pkg.sv ***
// Constants shared by the buffer ECC block and its code helpers.
// Assumes one 100 MHz clock and a 32-bit APB register bus.
package pbe_pkg;
  // ----------------------------------------------------------------
  // Code geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int PAR_W  = 6;
  localparam int CODE_W = DATA_W + PAR_W + 1;
  localparam int NBUF   = 4;
  localparam int BUF_RX  = 0;
  localparam int BUF_TX  = 1;
  localparam int BUF_P2A = 2;
  localparam int BUF_A2P = 3;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CAP     = 8'h00;
  localparam logic [7:0] OFF_CAP2    = 8'h04;
  localparam logic [7:0] OFF_STAT    = 8'h08;
  localparam logic [7:0] OFF_MASK    = 8'h0c;
  localparam logic [7:0] OFF_SEC_CNT = 8'h10;
  localparam logic [7:0] OFF_DED_CNT = 8'h14;
  localparam logic [7:0] OFF_INJ     = 8'h18;
  localparam int CAP_AER_BIT  = 31;
  localparam int CAP2_GEN_BIT = 1;
  localparam int CAP2_CHK_BIT = 2;
  localparam int STAT_DED_LSB = 4;
  localparam logic [31:0] CAP_RST  = 32'h0000_0000;
  localparam logic [31:0] CAP2_RST = 32'h0000_0000;
  localparam logic [7:0]  MASK_RST = 8'h00;
  localparam logic [7:0]  INJ_RST  = 8'h00;
  localparam logic [31:0] CNT_RST  = 32'h0000_0000;
  // Code bit positions flipped by the error injector
  localparam int INJ_BIT_A = 3;
  localparam int INJ_BIT_B = 5;
  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** design/pbe_enc.sv ***
// Extended Hamming encoder: bit 0 overall parity, powers of two check.
// Assumes pure combinational use inside the buffer write path.
`timescale 1ns/100ps
module pbe_enc import pbe_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int PW = PAR_W,
  parameter int CW = DW + PW + 1
) (
  input  wire logic [DW-1:0] data_i,  // Raw word
  output logic      [CW-1:0] code_o   // Protected word
);
  logic [CW-1:0] c;
  always_comb begin
    int j;
    logic par;
    j = 0;
    par = 1'b0;
    c = '0;
    for (int i = 1; i < CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = data_i[j];
        j++;
      end
    end
    for (int p = 0; p < PW; p++) begin
      par = 1'b0;
      for (int i = 1; i < CW; i++) begin
        if (((i >> p) & 1) == 1) par ^= c[i];
      end
      c[1 << p] = par;
    end
    c[0] = ^c[CW-1:1];
  end
  assign code_o = c;
endmodule

// *** design/pbe_dec.sv ***
// Extended Hamming decoder: fixes one bit, flags two.
// Assumes the layout written by pbe_enc.
`timescale 1ns/100ps
module pbe_dec import pbe_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int PW = PAR_W,
  parameter int CW = DW + PW + 1
) (
  input  wire logic [CW-1:0] code_i,    // Stored word
  output logic      [DW-1:0] data_o,    // Corrected word
  output logic               single_o,  // One bit fixed
  output logic               double_o   // Two bits, uncorrected
);
  always_comb begin
    int j;
    int syn;
    logic ovr;
    logic [CW-1:0] c;
    j = 0;
    syn = 0;
    c = code_i;
    ovr = ^code_i;
    for (int p = 0; p < PW; p++) begin
      logic par;
      par = 1'b0;
      for (int i = 1; i < CW; i++) begin
        if (((i >> p) & 1) == 1) par ^= code_i[i];
      end
      if (par) syn = syn | (1 << p);
    end
    single_o = ovr;
    double_o = !ovr && (syn != 0);
    // Flip the pointed bit; syndrome 0 means only bit 0 was hit
    if (ovr && syn > 0 && syn < CW) c[syn] = ~c[syn];
    data_o = '0;
    for (int i = 1; i < CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        data_o[j] = c[i];
        j++;
      end
    end
  end
endmodule

// *** design/pbe_top.sv ***
// Four ECC-protected link buffers with error effects and APB registers.
// Assumes APB master on sys_clk_i; buffer ports driven by link logic.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module pbe_top import pbe_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic                 sys_clk_i,        // Clock
  input  wire logic                 rst_i,            // Sync reset
  input  wire logic                 psel_i,           // APB select
  input  wire logic                 penable_i,        // APB enable
  input  wire logic                 pwrite_i,         // APB write
  input  wire logic [7:0]           paddr_i,          // APB address
  input  wire logic [31:0]          pwdata_i,         // APB write data
  output logic      [31:0]          prdata_o,         // APB read data
  output logic                      pready_o,         // APB ready
  output logic                      pslverr_o,        // APB error
  input  wire logic [NBUF-1:0]      buf_wr_en_i,      // Store strobe
  input  wire logic [NBUF*AW-1:0]   buf_wr_addr_i,    // Store index
  input  wire logic [NBUF*DATA_W-1:0] buf_wr_data_i,  // Store data
  input  wire logic [NBUF-1:0]      buf_rd_en_i,      // Fetch strobe
  input  wire logic [NBUF*AW-1:0]   buf_rd_addr_i,    // Fetch index
  input  wire logic                 a2p_rd_write_i,   // Fetch is write txn
  output logic [NBUF*DATA_W-1:0]    buf_rd_data_o,    // Fetched data
  output logic [NBUF-1:0]           buf_rd_valid_o,   // Fetched pulse
  output logic                      fabric_write_data_error_o, // Pulse
  output logic                      fabric_read_data_error_o,  // Pulse
  output logic                      tlp_mark_error_o, // Poison pulse
  output logic                      tlp_discard_o,    // Drop pulse
  output logic                      cpl_timeout_o,    // Timeout pulse
  output logic                      bresp_valid_o,    // Write resp pulse
  output logic [1:0]                slave_port_write_response_o, // BRESP
  output logic                      ecrc_gen_en_o,    // ECRC generate
  output logic                      ecrc_chk_en_o,    // ECRC check
  output logic                      irq_o             // Level interrupt
);
  // ----------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------
  logic [NBUF-1:0]   dec_sec;
  logic [NBUF-1:0]   dec_ded;
  logic [NBUF-1:0]   sec_ev;
  logic [NBUF-1:0]   ded_ev;
  logic [DATA_W-1:0] rd_data_q [NBUF];
  logic [NBUF-1:0]   rd_valid_q;
  logic [7:0]        inj_q;

  for (genvar b = 0; b < NBUF; b++) begin : g_buf
    logic [CODE_W-1:0] mem [DEPTH];
    logic [CODE_W-1:0] wr_code;
    logic [CODE_W-1:0] flip;
    logic [DATA_W-1:0] fixed;
    logic [AW-1:0]     waddr;
    logic [AW-1:0]     raddr;
    assign waddr = buf_wr_addr_i[b*AW +: AW];
    assign raddr = buf_rd_addr_i[b*AW +: AW];
    pbe_enc u_enc (
      .data_i (buf_wr_data_i[b*DATA_W +: DATA_W]),
      .code_o (wr_code)
    );
    // Injector lets software prove the detection path in place
    always_comb begin
      flip = '0;
      flip[INJ_BIT_A] = inj_q[b] | inj_q[STAT_DED_LSB+b];
      flip[INJ_BIT_B] = inj_q[STAT_DED_LSB+b];
    end
    always_ff @(posedge sys_clk_i) begin
      if (buf_wr_en_i[b]) begin
        mem[waddr] <= wr_code ^ flip;
      end
    end
    pbe_dec u_dec (
      .code_i   (mem[raddr]),
      .data_o   (fixed),
      .single_o (dec_sec[b]),
      .double_o (dec_ded[b])
    );
    assign sec_ev[b] = buf_rd_en_i[b] & dec_sec[b];
    assign ded_ev[b] = buf_rd_en_i[b] & dec_ded[b];
    // Data passes on whatever the check found; errors go to side paths
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        rd_data_q[b] <= '0;
      end else if (buf_rd_en_i[b]) begin
        rd_data_q[b] <= fixed;
      end
    end
    assign buf_rd_data_o[b*DATA_W +: DATA_W] = rd_data_q[b];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_valid_q <= '0;
    end else begin
      rd_valid_q <= buf_rd_en_i;
    end
  end
  assign buf_rd_valid_o = rd_valid_q;

  // ----------------------------------------------------------------
  // Double-error effects
  // ----------------------------------------------------------------
  logic [31:0] cap_q;
  logic [31:0] cap2_q;
  logic        ecrc_on;
  logic        p2a_err_q;
  logic        mark_q;
  logic        drop_q;
  logic        cto_q;
  logic        bv_q;
  logic [1:0]  bresp_q;

  assign ecrc_on = cap_q[CAP_AER_BIT] & cap2_q[CAP2_GEN_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      p2a_err_q <= 1'b0;
    end else begin
      p2a_err_q <= ded_ev[BUF_P2A];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mark_q <= 1'b0;
      drop_q <= 1'b0;
      cto_q  <= 1'b0;
    end else begin
      mark_q <= ded_ev[BUF_A2P] & ecrc_on;
      drop_q <= ded_ev[BUF_A2P] & ~ecrc_on;
      cto_q  <= ded_ev[BUF_A2P] & ~a2p_rd_write_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bv_q    <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      bv_q <= buf_rd_en_i[BUF_A2P] & a2p_rd_write_i;
      if (buf_rd_en_i[BUF_A2P] && a2p_rd_write_i) begin
        bresp_q <= dec_ded[BUF_A2P] ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  assign fabric_write_data_error_o   = p2a_err_q;
  assign fabric_read_data_error_o    = p2a_err_q;
  assign tlp_mark_error_o            = mark_q;
  assign tlp_discard_o               = drop_q;
  assign cpl_timeout_o               = cto_q;
  assign bresp_valid_o               = bv_q;
  assign slave_port_write_response_o = bresp_q;
  assign ecrc_gen_en_o = cap2_q[CAP2_GEN_BIT];
  assign ecrc_chk_en_o = cap2_q[CAP2_CHK_BIT];

  // ----------------------------------------------------------------
  // APB slave, one wait state so read data leaves a flop
  // ----------------------------------------------------------------
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic        hit;
  logic        acc;
  logic        wr_stb;
  logic [7:0]  stat_q;
  logic [7:0]  mask_q;
  logic [31:0] sec_cnt_q;
  logic [31:0] ded_cnt_q;
  logic        irq_q;

  assign acc    = psel_i & penable_i;
  assign wr_stb = acc & pready_q & pwrite_i & hit;

  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    unique case (paddr_i)
      OFF_CAP:     rd_mux = cap_q;
      OFF_CAP2:    rd_mux = cap2_q;
      OFF_STAT:    rd_mux = {24'h0, stat_q};
      OFF_MASK:    rd_mux = {24'h0, mask_q};
      OFF_SEC_CNT: rd_mux = sec_cnt_q;
      OFF_DED_CNT: rd_mux = ded_cnt_q;
      OFF_INJ:     rd_mux = {24'h0, inj_q};
      default:     hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q <= acc & ~pready_q;
      if (acc && !pready_q) begin
        pslverr_q <= ~hit;
        prdata_q  <= pwrite_i ? 32'h0 : rd_mux;
      end else if (!acc) begin
        pslverr_q <= 1'b0;
      end
    end
  end
  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cap_q  <= CAP_RST;
      cap2_q <= CAP2_RST;
      mask_q <= MASK_RST;
      inj_q  <= INJ_RST;
    end else if (wr_stb) begin
      if (paddr_i == OFF_CAP)  cap_q  <= pwdata_i;
      if (paddr_i == OFF_CAP2) cap2_q <= pwdata_i;
      if (paddr_i == OFF_MASK) mask_q <= pwdata_i[7:0];
      if (paddr_i == OFF_INJ)  inj_q  <= pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Status, counters, interrupt
  // ----------------------------------------------------------------
  logic [7:0] stat_clr;
  assign stat_clr = (wr_stb && paddr_i == OFF_STAT) ? pwdata_i[7:0] : 8'h00;

  // New events beat a same-cycle write-one-to-clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | {ded_ev, sec_ev};
    end
  end

  // Counters wrap; software polls and takes differences
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sec_cnt_q <= CNT_RST;
      ded_cnt_q <= CNT_RST;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'($countones(sec_ev));
      ded_cnt_q <= ded_cnt_q + 32'($countones(ded_ev));
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end
  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  p2a_flags_a: assert property (ded_ev[BUF_P2A] |=>
    fabric_write_data_error_o && fabric_read_data_error_o)
    else $error("p2a double error flags missing");
  a2p_mark_a: assert property (ded_ev[BUF_A2P] && ecrc_on |=>
    tlp_mark_error_o && !tlp_discard_o)
    else $error("a2p mark missing");
  a2p_drop_a: assert property (ded_ev[BUF_A2P] && !ecrc_on |=>
    tlp_discard_o && !tlp_mark_error_o)
    else $error("a2p discard missing");
  a2p_cto_a: assert property (ded_ev[BUF_A2P] && !a2p_rd_write_i |=>
    cpl_timeout_o && !bresp_valid_o)
    else $error("completion timeout missing");
  a2p_bresp_a: assert property (ded_ev[BUF_A2P] && a2p_rd_write_i |=>
    bresp_valid_o && slave_port_write_response_o == RESP_SLVERR)
    else $error("slave error response missing");
  sec_count_a: assert property ($countones(sec_ev) == 1 |=>
    sec_cnt_q == $past(sec_cnt_q) + 32'h1)
    else $error("single counter step wrong");
  rx_forward_a: assert property (buf_rd_en_i[BUF_RX] |=>
    buf_rd_valid_o[BUF_RX] &&
    (!$past(dec_ded[BUF_RX]) || ded_cnt_q != $past(ded_cnt_q)))
    else $error("rx data not forwarded");
  tx_ded_a: assert property (ded_ev[BUF_TX] |=>
    buf_rd_valid_o[BUF_TX] && stat_q[STAT_DED_LSB+BUF_TX])
    else $error("tx double not reported");
  rx_stat_a: assert property (sec_ev[BUF_RX] |=>
    stat_q[BUF_RX] ##1 stat_q[BUF_RX] || !mask_q[BUF_RX] || irq_o)
    else $error("rx single not reported");
  irq_level_a: assert property (|(stat_q & mask_q) |=> irq_o)
    else $error("interrupt not raised");

  ded_seen_c: cover property (ded_ev[BUF_A2P] && a2p_rd_write_i);
  sec_seen_c: cover property (sec_ev[BUF_RX]);
  irq_seen_c: cover property (irq_o ##1 !irq_o);
endmodule

// *** tb/pbe_fabric_model.sv ***
// Fabric-side partner: counts every error pulse the block raises.
// Assumes one-cycle pulses on the system clock, sync active-high reset.
`timescale 1ns/100ps
module pbe_fabric_model import pbe_pkg::*; (
  input  wire logic       clk_i,      // Clock
  input  wire logic       rst_i,      // Sync reset
  input  wire logic [5:0] pulse_i,    // Fabric error pulses
  output logic      [15:0] cnt_o [6]  // Pulses seen
);
  // ------------------------------------------------------------
  // Pulse counters
  // ------------------------------------------------------------
  // Counting, not sampling, so a stray or doubled pulse still shows
  for (genvar i = 0; i < 6; i++) begin : g_cnt
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_o[i] <= 16'h0000;
      end else if (pulse_i[i]) begin
        cnt_o[i] <= cnt_o[i] + 16'h0001;
      end
    end
  end
endmodule

// *** tb/tb_pbe_top.sv ***
// Self-checking bench: APB registers, buffer words, error effects.
// Assumes pbe_pkg, the design files and pbe_fabric_model come first.
`timescale 1ns/100ps
module tb_pbe_top import pbe_pkg::*; ();
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic         clk, rst, psel, pen, pwr, pready, perr, err;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd, cap, cap2, mask, sec_n, ded_n;
  logic [3:0]   wr_en, rd_en, rd_vld;
  logic [15:0]  wr_adr, rd_adr;
  logic [127:0] wr_dat, rd_dat;
  logic [5:0]   fx;
  logic [1:0]   bresp;
  logic         a2p_wr, gen_en, chk_en, irq;
  logic [15:0]  seen [6];
  int           n_errors, n_tests, ex [6];
  int           cyc = 0;

  pbe_top i_dut (
    .sys_clk_i                   (clk),
    .rst_i                       (rst),
    .psel_i                      (psel),
    .penable_i                   (pen),
    .pwrite_i                    (pwr),
    .paddr_i                     (paddr),
    .pwdata_i                    (pwdata),
    .prdata_o                    (prdata),
    .pready_o                    (pready),
    .pslverr_o                   (perr),
    .buf_wr_en_i                 (wr_en),
    .buf_wr_addr_i               (wr_adr),
    .buf_wr_data_i               (wr_dat),
    .buf_rd_en_i                 (rd_en),
    .buf_rd_addr_i               (rd_adr),
    .a2p_rd_write_i              (a2p_wr),
    .buf_rd_data_o               (rd_dat),
    .buf_rd_valid_o              (rd_vld),
    .fabric_write_data_error_o   (fx[5]),
    .fabric_read_data_error_o    (fx[4]),
    .tlp_mark_error_o            (fx[3]),
    .tlp_discard_o               (fx[2]),
    .cpl_timeout_o               (fx[1]),
    .bresp_valid_o               (fx[0]),
    .slave_port_write_response_o (bresp),
    .ecrc_gen_en_o               (gen_en),
    .ecrc_chk_en_o               (chk_en),
    .irq_o                       (irq)
  );

  pbe_fabric_model i_fab (
    .clk_i   (clk),
    .rst_i   (rst),
    .pulse_i (fx),
    .cnt_o   (seen)
  );

  // ------------------------------------------------------------
  // Clock, watchdog, report
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ------------------------------------------------------------
  // Expected fabric effects {wderr, rderr, mark, drop, cto, bvalid}
  // ------------------------------------------------------------
  function automatic logic [5:0] exp_fx(int b, bit dbl, bit wtx);
    bit on;
    on = cap[CAP_AER_BIT] & cap2[CAP2_GEN_BIT];
    exp_fx = 6'h00;
    if (b == BUF_A2P) exp_fx[0] = wtx;
    if (!dbl) return exp_fx;
    if (b == BUF_P2A) exp_fx[5:4] = 2'b11;
    if (b == BUF_A2P) exp_fx[3:1] = {on, !on, !wtx};
  endfunction

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Waits on pready with a bound; the slave's latency is not assumed
  task automatic apb(bit w, logic [7:0] a, logic [31:0] wd);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic cfg(logic [31:0] c, logic [31:0] c2);
    cap  = c;
    cap2 = c2;
    apb(1'b1, OFF_CAP, c);
    apb(1'b1, OFF_CAP2, c2);
    apb(1'b0, OFF_CAP, 32'h0);
    #1;
    chk("cap", c, rd);
    chk("ecrc_en", {30'h0, c2[2:1]}, {30'h0, chk_en, gen_en});
  endtask

  // Mode 0 clean, 1 one flipped bit, 2 two flipped bits
  task automatic one_word(int b, int mode, bit wtx);
    logic [31:0] d;
    logic [3:0]  a;
    logic [7:0]  st;
    logic [5:0]  fe;
    logic [1:0]  br;
    d  = $urandom;
    a  = 4'($urandom);
    st = (mode == 1) ? 8'h01 << b : (mode == 2) ? 8'h10 << b : 8'h00;
    fe = exp_fx(b, mode == 2, wtx);
    br = (mode == 2) ? RESP_SLVERR : RESP_OKAY;
    mask = $urandom & 32'hff;
    apb(1'b1, OFF_MASK, mask);
    apb(1'b1, OFF_INJ, {24'h0, st});
    @(posedge clk);
    wr_en <= 4'h1 << b;
    wr_adr[b*4 +: 4] <= a;
    wr_dat[b*32 +: 32] <= d;
    @(posedge clk);
    wr_en <= 4'h0;
    rd_en <= 4'h1 << b;
    rd_adr[b*4 +: 4] <= a;
    a2p_wr <= wtx;
    @(posedge clk);
    rd_en <= 4'h0;
    #1;
    chk("valid", {28'h0, 4'h1 << b}, {28'h0, rd_vld});
    if (mode < 2) chk("data", d, rd_dat[b*32 +: 32]);
    chk("data_err", {30'h0, fe[5:4]}, {30'h0, fx[5:4]});
    chk("mark_drop", {30'h0, fe[3:2]}, {30'h0, fx[3:2]});
    chk("cto_bvalid", {30'h0, fe[1:0]}, {30'h0, fx[1:0]});
    if (b == BUF_A2P && wtx)
      chk("bresp", {30'h0, br}, {30'h0, bresp});
    for (int i = 0; i < 6; i++) ex[i] += int'(fe[i]);
    sec_n += 32'(mode == 1);
    ded_n += 32'(mode == 2);
    apb(1'b0, OFF_SEC_CNT, 32'h0);
    chk("sec_cnt", sec_n, rd);
    apb(1'b0, OFF_DED_CNT, 32'h0);
    chk("ded_cnt", ded_n, rd);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("status", {24'h0, st}, rd);
    chk("irq", {31'h0, |(st & mask[7:0])}, {31'h0, irq});
    apb(1'b1, OFF_STAT, 32'hff);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(82724));
    rst = 1'b1;
    {psel, pen, pwr, paddr, pwdata, wr_en, rd_en, a2p_wr} = '0;
    {wr_adr, rd_adr, wr_dat, sec_n, ded_n, cap, cap2} = '0;
    ex = '{default: 0};
    n_errors = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset_val", 32'h0, rd);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 8'h06, 32'hffff_ffff);
    chk("unaligned", 32'h1, {31'h0, err});
    // Each ECRC setting crossed with every buffer and error kind
    for (int k = 0; k < 4; k++) begin
      cfg({k[0], 31'h0}, {29'h0, k[1], k[0] ^ k[1], 1'b0});
      for (int b = 0; b < NBUF; b++)
        for (int m = 0; m < 3; m++) one_word(b, m, k[1]);
    end
    for (int r = 0; r < 60; r++) begin
      cfg($urandom & 32'h8000_0000, $urandom & 32'h6);
      one_word(int'($urandom % 4), int'($urandom % 3), 1'($urandom));
    end
    for (int i = 0; i < 6; i++) chk("pulses", ex[i], {16'h0, seen[i]});
    end_sim();
  end
endmodule
